// *** dcc_bank_track.sv ***
`timescale 1ns/1ns
`default_nettype none
// tracks which of the banks have a row open
module dcc_bank_track
    import dcc_pkg::*;
#(
    parameter int NB = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_code,
    input wire logic [dcc_pkg::BANK_W-1:0] bank,
    input wire logic auto_pre,
    output logic [NB-1:0] open_map,
    output logic any_open
);
    import dcc_pkg::*;

    wire [NB-1:0] next_open; // per-bank next open flag, one net bit each
    assign any_open = |open_map; // some row open somewhere

    // one open flag per bank, selected by bank select [R15]
    for (genvar b = 0; b < NB; b++) begin : g_bank
        wire hit = cmd_valid && (bank == BANK_W'(b));
        wire act = hit && (cmd_code == CMD_ACTIVATE);
        wire pre_one = hit && (cmd_code == CMD_PRECHARGE) && !auto_pre;
        wire pre_all = cmd_valid && (cmd_code == CMD_PRECHARGE) && auto_pre;
        wire rw_ap = hit && auto_pre &&
            ((cmd_code == CMD_READ) || (cmd_code == CMD_WRITE));
        // activate opens, precharge or auto-close clears, else hold
        assign next_open[b] = act ? 1'b1 :
            (pre_one || pre_all || rw_ap) ? 1'b0 : open_map[b];
        bank_open_a: assert property (@(posedge clk) disable iff (rst) // [R15]
            act |=> open_map[b])
            else $error("activate did not open bank");
    end

    // all open flags kept in one register, so one process drives it
    always_ff @(posedge clk) begin
        if (rst) begin
            open_map <= '0;
        end else begin
            open_map <= next_open;
        end
    end
endmodule
`default_nettype wire

// *** dcc_input_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
// command-input front end with clock-gate power control
module dcc_input_ctrl
    import dcc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic CLOCK,
    input wire logic RST,
    // link pins
    input wire logic TIMING_STROBE_P,
    input wire logic TIMING_STROBE_N,
    input wire logic CLOCK_GATE,
    input wire logic RANK_SEL_N,
    input wire logic ROW_STROBE_N,
    input wire logic COL_STROBE_N,
    input wire logic WRITE_STROBE_N,
    input wire logic [dcc_pkg::BANK_W-1:0] BANK_SELECT,
    input wire logic [dcc_pkg::ADDR_W-1:0] ADDR,
    input wire logic TERMINATION_ENABLE,
    // register bus
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // decoded command
    output logic CMD_VALID,
    output logic [3:0] CMD_CODE,
    output logic [dcc_pkg::BANK_W-1:0] CMD_BANK,
    output logic [dcc_pkg::ADDR_W-1:0] CMD_ADDR,
    // power and buffer control
    output dcc_pkg::dcc_pwr_t POWER_STATE,
    output logic INT_CLOCK_EN,
    output logic OUT_DRIVER_EN,
    output logic CMD_BUF_EN,
    output logic CLOCK_BUF_EN,
    output logic TERM_BUF_EN,
    output logic GATE_BUF_EN,
    output logic TERM_ACTIVE,
    output logic [dcc_pkg::NUM_BANKS-1:0] BANK_OPEN,
    // programmed latencies and burst
    output logic [3:0] READ_LATENCY,
    output logic [3:0] WRITE_LATENCY,
    output logic [3:0] EXTRA_LATENCY,
    output logic BURST_LEN4,
    output logic BURST_INTERLEAVE
);
    import dcc_pkg::*;

    localparam int SYNC_W = 7 + BANK_W + ADDR_W + 1;

    // synchronised pins
    logic [SYNC_W-1:0] pins_s;
    logic p_s, n_s, gate_s, sel_n_s, row_n_s, col_n_s, wr_n_s, term_s;
    logic [BANK_W-1:0] bank_s;
    logic [ADDR_W-1:0] addr_s;

    dcc_sync #(.W(SYNC_W)) u_sync (
        .clk(CLOCK),
        .rst(RST),
        .din({TIMING_STROBE_P, TIMING_STROBE_N, CLOCK_GATE, RANK_SEL_N,
              ROW_STROBE_N, COL_STROBE_N, WRITE_STROBE_N, BANK_SELECT,
              ADDR, TERMINATION_ENABLE}),
        .dout(pins_s)
    );
    assign {p_s, n_s, gate_s, sel_n_s, row_n_s, col_n_s, wr_n_s, bank_s,
            addr_s, term_s} = pins_s;

    // strobe-pair crossing detection
    logic p_prev; // previous synced positive leg
    logic gate_last; // gate level at previous crossing or at self-refresh exit
    dcc_pwr_t state, next_state;
    wire crossing = CLOCK_BUF_EN && p_s && !p_prev && !n_s; // [R1]
    wire [3:0] code = {sel_n_s, row_n_s, col_n_s, wr_n_s}; // [R10] [R16]
    wire active = (state == ST_ACTIVE);
    wire gate_fall = crossing && !gate_s && gate_last; // [R4]
    wire refresh_cmd = (code == CMD_REFRESH);
    logic any_open; // from bank tracker
    // a command is taken only on a crossing, when awake and selected
    wire take_cmd = crossing && active && gate_s && CMD_BUF_EN &&
        !sel_n_s; // [R9] [R17]
    wire mask_cmd = crossing && active && gate_s && sel_n_s; // [R9]

    // remember previous positive leg
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            p_prev <= 1'b0;
        end else begin
            p_prev <= p_s;
        end
    end

    // gate level as last registered at a crossing or at self-refresh exit
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            gate_last <= 1'b0;
        end else if (state == ST_SELF_REF && gate_s) begin
            gate_last <= 1'b1;
        end else if (crossing) begin
            gate_last <= gate_s;
        end
    end

    // power state transitions
    always_comb begin
        next_state = state;
        case (state)
            ST_ACTIVE: begin
                if (gate_fall) begin
                    // bank state picks the low-power mode [R3]
                    if (refresh_cmd && !sel_n_s && !any_open) begin
                        next_state = ST_SELF_REF;
                    end else if (any_open) begin
                        next_state = ST_ACT_PD;
                    end else begin
                        next_state = ST_PRE_PD;
                    end
                end
            end
            ST_PRE_PD, ST_ACT_PD: begin
                // exit only at a crossing with the gate high [R4]
                if (crossing && gate_s) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_SELF_REF: begin
                // exit on gate high, no strobe edge needed [R5]
                if (gate_s) begin
                    next_state = ST_ACTIVE;
                end
            end
            default: begin
                next_state = ST_ACTIVE;
            end
        endcase
    end

    // buffer enables for the next state
    wire nx_act = (next_state == ST_ACTIVE);
    wire nx_pd = (next_state == ST_PRE_PD) || (next_state == ST_ACT_PD);

    // state and buffer control registers
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state <= ST_ACTIVE;
            INT_CLOCK_EN <= 1'b1;
            OUT_DRIVER_EN <= 1'b1;
            CMD_BUF_EN <= 1'b1;
            CLOCK_BUF_EN <= 1'b1;
            TERM_BUF_EN <= 1'b1;
        end else begin
            state <= next_state;
            INT_CLOCK_EN <= nx_act; // [R2]
            OUT_DRIVER_EN <= nx_act; // [R2]
            CMD_BUF_EN <= nx_act; // [R7] [R8]
            CLOCK_BUF_EN <= nx_act || nx_pd; // [R7] [R8]
            TERM_BUF_EN <= nx_act || nx_pd; // [R7] [R8]
        end
    end
    assign GATE_BUF_EN = 1'b1; // gate receiver never switched off
    assign POWER_STATE = state;

    // termination request through its buffer
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            TERM_ACTIVE <= 1'b0;
        end else begin
            TERM_ACTIVE <= term_s && TERM_BUF_EN;
        end
    end

    // registered command output, one-cycle pulse
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            CMD_VALID <= 1'b0;
            CMD_CODE <= CMD_NOP;
            CMD_BANK <= '0;
            CMD_ADDR <= '0;
        end else begin
            CMD_VALID <= take_cmd;
            if (take_cmd) begin
                CMD_CODE <= code;
                CMD_BANK <= bank_s;
                CMD_ADDR <= addr_s;
            end
        end
    end

    // open-row bookkeeping; address bit 10 is auto/all precharge
    dcc_bank_track #(.NB(NUM_BANKS)) u_banks (
        .clk(CLOCK),
        .rst(RST),
        .cmd_valid(take_cmd),
        .cmd_code(code),
        .bank(bank_s),
        .auto_pre(addr_s[10]),
        .open_map(BANK_OPEN),
        .any_open(any_open)
    );

    // bus slave: address phase capture
    logic wr_pend, rd_pend; // data phase pending
    logic [7:0] addr_q; // captured offset
    logic [CNT_W-1:0] cmd_count, mask_count;
    wire addr_phase = HSEL && HTRANS[1] && HREADY;
    wire in_map = (HADDR[31:8] == 24'h000000);

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_pend <= addr_phase && HWRITE && in_map;
            rd_pend <= addr_phase && !HWRITE;
            if (addr_phase) begin
                addr_q <= in_map ? HADDR[7:0] : 8'hff;
            end
        end
    end
    assign HREADYOUT = !rd_pend; // one wait state on reads
    assign HRESP = 1'b0;

    // config write decode; an illegal write is dropped whole
    wire [3:0] w_rl = HWDATA[CFG_RL_LSB +: 4];
    wire [3:0] w_wl = HWDATA[CFG_WL_LSB +: 4];
    wire [1:0] w_al = HWDATA[CFG_AL_LSB +: 2];
    wire cfg_ok = (w_rl >= RL_MIN) && (w_rl <= RL_MAX) &&
        (w_wl >= WL_MIN) && (w_wl <= WL_MAX) &&
        (w_al != 2'h3); // [R11] [R12] [R13]
    wire cfg_we = wr_pend && (addr_q == OFS_CONFIG) && cfg_ok;
    logic [1:0] al_sel; // extra latency selection

    // latency and burst configuration
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            READ_LATENCY <= RL_RESET;
            WRITE_LATENCY <= WL_RESET;
            al_sel <= AL_RESET;
            BURST_LEN4 <= 1'b0;
            BURST_INTERLEAVE <= 1'b0;
        end else if (cfg_we) begin
            READ_LATENCY <= w_rl; // [R11]
            WRITE_LATENCY <= w_wl; // [R12]
            al_sel <= w_al; // [R13]
            BURST_LEN4 <= HWDATA[CFG_BL4_BIT]; // [R14]
            BURST_INTERLEAVE <= HWDATA[CFG_ILV_BIT]; // [R14]
        end
    end

    // posted extra latency derived from read latency
    wire [3:0] next_extra = (al_sel == AL_MINUS1) ? READ_LATENCY - 4'h1 :
        (al_sel == AL_MINUS2) ? READ_LATENCY - 4'h2 : 4'h0; // [R13]
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            EXTRA_LATENCY <= 4'h0;
        end else begin
            EXTRA_LATENCY <= next_extra;
        end
    end

    // accepted and masked command counters
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            cmd_count <= '0;
            mask_count <= '0;
        end else begin
            cmd_count <= cmd_count + CNT_W'(take_cmd);
            mask_count <= mask_count + CNT_W'(mask_cmd);
        end
    end

    // read mux, sampled during the wait state
    wire [31:0] cfg_word = {18'h00000, BURST_INTERLEAVE, BURST_LEN4,
        2'h0, al_sel, WRITE_LATENCY, READ_LATENCY};
    wire [31:0] sts_word = {12'h000, EXTRA_LATENCY, BANK_OPEN,
        6'h00, 2'(state)};
    wire [31:0] rd_mux = (addr_q == OFS_CONFIG) ? cfg_word :
        (addr_q == OFS_STATUS) ? sts_word :
        (addr_q == OFS_CMD_COUNT) ? 32'(cmd_count) :
        (addr_q == OFS_MASK_COUNT) ? 32'(mask_count) : 32'h00000000;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            HRDATA <= 32'h00000000;
        end else if (rd_pend) begin
            HRDATA <= rd_mux;
        end
    end

    // checks on the power, command and latency behaviour
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    cmd_at_crossing_a: assert property ( // [R1]
        CMD_VALID |-> $past(crossing) && $past(!sel_n_s))
        else $error("command not taken at a crossing");
    clock_gating_a: assert property ( // [R2]
        (state != ST_ACTIVE) |-> !INT_CLOCK_EN && !OUT_DRIVER_EN)
        else $error("clocks left running in low power");
    active_pd_entry_a: assert property ( // [R3]
        active && gate_fall && any_open |=> state == ST_ACT_PD)
        else $error("open row did not give active power-down");
    pd_hold_a: assert property ( // [R4]
        (state == ST_PRE_PD || state == ST_ACT_PD) && !crossing
        |=> $stable(state))
        else $error("power-down left without a crossing");
    sr_exit_a: assert property ( // [R5]
        state == ST_SELF_REF && gate_s |=> active ##1 INT_CLOCK_EN)
        else $error("self-refresh exit missed");
    pd_buffers_a: assert property ( // [R7]
        (state == ST_PRE_PD || state == ST_ACT_PD) |->
        CLOCK_BUF_EN && TERM_BUF_EN && !CMD_BUF_EN)
        else $error("wrong buffers in power-down");
    sr_buffers_a: assert property ( // [R8]
        state == ST_SELF_REF |->
        !CLOCK_BUF_EN && !TERM_BUF_EN && !CMD_BUF_EN && GATE_BUF_EN)
        else $error("wrong buffers in self-refresh");
    deselect_a: assert property ( // [R9]
        crossing && sel_n_s |=> !CMD_VALID ##1 $stable(cmd_count))
        else $error("deselected command accepted");
    lowpower_quiet_a: assert property ( // [R17]
        !active |=> !CMD_VALID)
        else $error("command accepted in low power");
    latency_range_a: assert property ( // [R11] [R12]
        READ_LATENCY inside {[RL_MIN:RL_MAX]} &&
        WRITE_LATENCY inside {[WL_MIN:WL_MAX]})
        else $error("latency out of range");
    extra_latency_a: assert property ( // [R13]
        al_sel == AL_MINUS2 ##1 $stable(READ_LATENCY) |->
        EXTRA_LATENCY == READ_LATENCY - 4'h2)
        else $error("extra latency wrong");
endmodule
`default_nettype wire

// *** dcc_link_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// controller model: strobe pair, gate, command pins, termination
module dcc_link_model (
    output logic strobe_p,
    output logic strobe_n,
    output logic gate,
    output logic sel_n,
    output logic row_n,
    output logic col_n,
    output logic wr_n,
    output logic [2:0] bank,
    output logic [13:0] addr,
    output logic term_en
);
    // pair stands still between frames, rank deselected
    initial begin
        {strobe_p, strobe_n, gate, term_en} = 4'h6;
        {sel_n, row_n, col_n, wr_n, bank, addr} = '1;
    end
    // gate and termination are plain levels
    task automatic set_level(input logic g, input logic t);
        gate = g;
        term_en = t;
    endtask
    // one strobe period, command taken at its crossing
    task automatic frame(input logic [3:0] c, input logic [2:0] b,
        input logic [13:0] a, input logic g);
        gate = g;
        {sel_n, row_n, col_n, wr_n} = c;
        {bank, addr} = {b, a};
        #62;
        {strobe_p, strobe_n} = 2'h2;
        #63;
        {strobe_p, strobe_n} = 2'h1;
        // released lines show the inverse of the last value, except rank select, which goes high
        {sel_n, row_n, col_n, wr_n, bank, addr} = ~{1'b0, c[2:0], b, a};
    endtask
endmodule
`default_nettype wire

// *** dcc_pkg.sv ***
// Notes on behaviour
// R1: sample inputs at rising/falling strobe-pair crossing
// R2: clock-gate high enables clocks, buffers, drivers
// R3: gate low: idle banks precharge/self-refresh, else active
// R4: gate sampled at crossing for power-down, refresh entry
// R5: self-refresh exit seen on gate high, no edge
// R6: controller keeps gate high through reads, writes
// R7: power-down keeps only clock, termination, gate buffers
// R8: self-refresh keeps only the gate buffer
// R9: commands ignored while rank select is high
// R10: rank select is one bit of command code
// R11: read latency programmable from 5 to 11
// R12: write latency programmable from 5 to 9
// R13: posted extra latency 0, rl-1 or rl-2
// R14: burst length 4 or 8, sequential or interleaved
// R15: eight banks chosen by three-bit bank select
// R16: row, column, write strobes plus select form command
// R17: no command accepted while in a low-power state
// R18: controller enters low power in matching bank state
package dcc_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CMD_COUNT = 8'h08;
    localparam logic [7:0] OFS_MASK_COUNT = 8'h0c;
    // config field positions
    localparam int CFG_RL_LSB = 0;
    localparam int CFG_WL_LSB = 4;
    localparam int CFG_AL_LSB = 8;
    localparam int CFG_BL4_BIT = 12;
    localparam int CFG_ILV_BIT = 13;
    // status field positions
    localparam int STS_PWR_LSB = 0;
    localparam int STS_BANK_LSB = 8;
    localparam int STS_EXTRA_LSB = 16;
    // config reset values
    localparam logic [3:0] RL_RESET = 4'h5;
    localparam logic [3:0] WL_RESET = 4'h5;
    localparam logic [1:0] AL_RESET = 2'h0;
    // legal latency ranges
    localparam logic [3:0] RL_MIN = 4'h5;
    localparam logic [3:0] RL_MAX = 4'hb;
    localparam logic [3:0] WL_MIN = 4'h5;
    localparam logic [3:0] WL_MAX = 4'h9;
    // extra latency selections
    localparam logic [1:0] AL_ZERO = 2'h0;
    localparam logic [1:0] AL_MINUS1 = 2'h1;
    localparam logic [1:0] AL_MINUS2 = 2'h2;
    // pin widths
    localparam int BANK_W = 3;
    localparam int NUM_BANKS = 8;
    localparam int ADDR_W = 14;
    // command codes {rank_sel_n, row_n, col_n, wr_n}
    localparam logic [3:0] CMD_MODE_SET = 4'h0;
    localparam logic [3:0] CMD_REFRESH = 4'h1;
    localparam logic [3:0] CMD_PRECHARGE = 4'h2;
    localparam logic [3:0] CMD_ACTIVATE = 4'h3;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_CALIBRATE = 4'h6;
    localparam logic [3:0] CMD_NOP = 4'h7;
    // power states
    typedef enum logic [1:0] {
        ST_ACTIVE,
        ST_PRE_PD,
        ST_ACT_PD,
        ST_SELF_REF
    } dcc_pwr_t;
endpackage

// *** dcc_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser for pins from the link
module dcc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta; // first stage, read only by second

    // both stages clear on reset
    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule
`default_nettype wire

// *** tb_dcc_input_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
// bench: controller model on the link, bus master on the registers
module tb_dcc_input_ctrl;
    import dcc_pkg::*;
    logic clk = 1'b0, rst = 1'b1;
    wire logic sp, sn, ge, seln, rown, coln, wrn, term;
    wire logic [2:0] bank;
    wire logic [13:0] addr;
    logic hsel = 1'b0, hwrite = 1'b0, hrdy, hresp, cv, tact, bl4, ilv;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
    logic [1:0] htrans = 2'h0;
    logic [3:0] cc, rl, wl, xl;
    logic [2:0] cb;
    logic [13:0] ca;
    logic [7:0] bo;
    wire logic [5:0] en; // clock, driver, cmd, clock buf, term buf, gate buf
    dcc_pwr_t ps;
    int n_errors = 0, n_checks = 0, n_cmds = 0;
    dcc_link_model dcc_link_model_i (.strobe_p(sp), .strobe_n(sn),
        .gate(ge), .sel_n(seln), .row_n(rown), .col_n(coln), .wr_n(wrn),
        .bank(bank), .addr(addr), .term_en(term));
    dcc_input_ctrl dcc_input_ctrl_i (.CLOCK(clk), .RST(rst),
        .TIMING_STROBE_P(sp), .TIMING_STROBE_N(sn), .CLOCK_GATE(ge),
        .RANK_SEL_N(seln), .ROW_STROBE_N(rown), .COL_STROBE_N(coln),
        .WRITE_STROBE_N(wrn), .BANK_SELECT(bank), .ADDR(addr),
        .TERMINATION_ENABLE(term), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp),
        .CMD_VALID(cv), .CMD_CODE(cc), .CMD_BANK(cb), .CMD_ADDR(ca),
        .POWER_STATE(ps), .INT_CLOCK_EN(en[5]), .OUT_DRIVER_EN(en[4]),
        .CMD_BUF_EN(en[3]), .CLOCK_BUF_EN(en[2]), .TERM_BUF_EN(en[1]),
        .GATE_BUF_EN(en[0]), .TERM_ACTIVE(tact), .BANK_OPEN(bo),
        .READ_LATENCY(rl), .WRITE_LATENCY(wl), .EXTRA_LATENCY(xl),
        .BURST_LEN4(bl4), .BURST_INTERLEAVE(ilv));
    // free-running system clock
    always #5 clk = ~clk;
    // count accepted commands where the pulse is settled
    always @(negedge clk) if (cv === 1'b1) n_cmds++;
    // compare one value and count it
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h, expected %h", $time, got, exp);
        end
    endtask
    // counts, verdict, end of run
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // pass the edge where ready is sampled high; data taken before it
    task automatic wait_rdy(output logic [31:0] rd);
        int k;
        k = 0;
        @(negedge clk);
        while (hrdy !== 1'b1 && k < 20) begin
            @(negedge clk);
            k++;
        end
        rd = hrdata;
        if (k == 20) begin
            n_errors++;
            finish_test();
        end
        @(posedge clk);
    endtask
    // one single word transfer, address phase then data phase
    task automatic bus(input logic w, input logic [31:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        {hsel, haddr, htrans, hwrite} <= {1'b1, a, 2'h2, w};
        wait_rdy(rd);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
        wait_rdy(rd);
        @(negedge clk);
    endtask
    // one link frame, then let the synced result land
    task automatic send(input logic [3:0] c, input logic [2:0] b,
        input logic [13:0] a, input logic g);
        dcc_link_model_i.frame(c, b, a, g);
        repeat (2) @(negedge clk);
    endtask
    // state right after reset, config readback, unmapped place
    task automatic t_reset;
        check(ps, ST_ACTIVE);
        check({hresp, en}, 7'h3f);
        check({cc, bo, rl, wl, xl}, 24'h700550);
        bus(1'b0, OFS_CONFIG, 32'h0, d);
        check(d, 32'h55);
        bus(1'b0, 32'h10, 32'h0, d);
        check(d, 32'h0);
        $display("reset test done");
    endtask
    // every command code with its bank and address
    task automatic t_cmds;
        int n;
        for (int c = 0; c < 8; c++) begin
            n = n_cmds;
            send(4'(c), 3'(c), 14'(c + 32'h123), 1'b1);
            check(n_cmds - n, 1);
            check(cc, c);
            check(cb, c);
            check(ca, c + 32'h123);
        end
        check(bo, 8'h08);
        bus(1'b0, OFS_CMD_COUNT, 32'h0, d);
        check(d, 32'h8);
        $display("command test done");
    endtask
    // open a second bank, auto-close the first, read the map
    task automatic t_bank;
        send(CMD_ACTIVATE, 3'h7, 14'h0, 1'b1);
        check(bo, 8'h88);
        send(CMD_READ, 3'h3, 14'h0400, 1'b1);
        check(bo, 8'h80);
        bus(1'b0, OFS_STATUS, 32'h0, d);
        check(d, 32'h8000);
        $display("bank test done");
    endtask
    // deselected activate is masked and counted
    task automatic t_mask;
        logic [31:0] m;
        int n;
        bus(1'b0, OFS_MASK_COUNT, 32'h0, m);
        n = n_cmds;
        send(4'hb, 3'h1, 14'h0, 1'b1);
        check(n_cmds - n, 0);
        check(bo, 8'h80);
        bus(1'b0, OFS_MASK_COUNT, 32'h0, d);
        check(d, m + 1);
        $display("mask test done");
    endtask
    // active and precharge power-down, command refused inside
    task automatic t_pd;
        int n;
        dcc_link_model_i.set_level(1'b1, 1'b1);
        n = n_cmds;
        send(CMD_NOP, 3'h0, 14'h0, 1'b0);
        check(ps, ST_ACT_PD);
        check({en, tact}, 7'h0f);
        send(CMD_PRECHARGE, 3'h7, 14'h0, 1'b0);
        check(bo, 8'h80);
        send(CMD_NOP, 3'h0, 14'h0, 1'b1);
        check(ps, ST_ACTIVE);
        check(n_cmds - n, 0);
        send(CMD_PRECHARGE, 3'h0, 14'h0400, 1'b1);
        check(bo, 8'h00);
        send(CMD_NOP, 3'h0, 14'h0, 1'b0);
        check(ps, ST_PRE_PD);
        send(CMD_NOP, 3'h0, 14'h0, 1'b1);
        check({ps, en}, {ST_ACTIVE, 6'h3f});
        $display("power-down test done");
    endtask
    // self-refresh entry by refresh code, exit on gate alone
    task automatic t_sref;
        int k;
        send(CMD_REFRESH, 3'h0, 14'h0, 1'b0);
        check(ps, ST_SELF_REF);
        check({en, tact}, 7'h02);
        dcc_link_model_i.set_level(1'b1, 1'b1);
        k = 0;
        while (ps !== ST_ACTIVE && k < 8) begin
            @(negedge clk);
            k++;
        end
        check(ps, ST_ACTIVE);
        if (k == 8) finish_test();
        $display("self-refresh test done");
    endtask
    // every legal latency, extra selection and burst mode, then bad ones
    task automatic t_cfg;
        logic [31:0] v, bad [5];
        int s, w;
        bad = '{32'h54, 32'h5c, 32'h45, 32'ha5, 32'h355};
        for (int r = 5; r < 12; r++) begin
            s = r % 3;
            w = 5 + (r - 5) % 5;
            v = 32'(r + (w << CFG_WL_LSB) + (s << CFG_AL_LSB)
                + ((r & 1) << CFG_BL4_BIT) + (((r >> 1) & 1) << CFG_ILV_BIT));
            bus(1'b1, OFS_CONFIG, v, d);
            @(negedge clk);
            check(rl, r);
            check(wl, w);
            check(xl, s == 0 ? 0 : r - s);
            check({ilv, bl4}, r & 3);
            bus(1'b0, OFS_CONFIG, 32'h0, d);
            check(d, v);
        end
        foreach (bad[i]) begin
            bus(1'b1, OFS_CONFIG, bad[i], d);
            bus(1'b0, OFS_CONFIG, 32'h0, d);
            check(d, v);
        end
        $display("config test done");
    endtask
    // reset for 12 cycles, then the scenarios in order
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        t_reset();
        t_cmds();
        t_bank();
        t_mask();
        t_pd();
        t_sref();
        t_cfg();
        finish_test();
    end
endmodule
`default_nettype wire
